// ---- dtp_top.sv ----
// Digital I/O port with four buses, source modes and trigger channels
`timescale 1ns/10ps
module dtp_top
	import dtp_pkg::*;
#(
	parameter int NUM_BUS = NUM_BUSES,   // Buses in the port
	parameter int BUS_W   = BUS_WIDTH    // Lines per bus
)
(
	// Clock and reset
	input  wire logic                     CLK,
	input  wire logic                     NRST,
	// Register port
	input  wire logic [7:0]               REG_ADDR,
	input  wire logic [REG_W-1:0]         REG_WDATA,
	input  wire logic                     REG_WR,
	input  wire logic                     REG_RD,
	output logic      [REG_W-1:0]         REG_RDATA,
	// Interrupt
	output logic                          IRQ,
	// Value sources
	input  wire logic [NUM_BUS*BUS_W-1:0] SEQ_VALUE,
	input  wire logic                     SEQ_VALID,
	input  wire logic [NUM_BUS*BUS_W-1:0] RES_VALUE,
	input  wire logic                     RES_VALID,
	// Parallel port pins
	input  wire logic [NUM_BUS*BUS_W-1:0] PORT_IN,
	output logic      [NUM_BUS*BUS_W-1:0] PORT_OUT,
	output logic      [NUM_BUS*BUS_W-1:0] PORT_OE_N,
	input  wire logic                     PORT_EXT_CLK,
	// Trigger pins
	input  wire logic [NUM_FRONT-1:0]     TRIG_FRONT_IN,
	output logic      [NUM_FRONT-1:0]     TRIG_FRONT_OUT,
	output logic      [NUM_FRONT-1:0]     TRIG_FRONT_OE_N,
	input  wire logic [NUM_BACK-1:0]      TRIG_BACK_IN,
	output logic      [NUM_BACK-1:0]      TRIG_BACK_OUT,
	output logic      [NUM_TRIG-1:0]      TRIG_LEVEL
);

	localparam int PW = NUM_BUS * BUS_W;   // Total port lines

	// Control registers written by software
	logic [1:0]         mode_reg;          // Output source
	logic               clk_ext_reg;       // External port clock
	logic [NUM_BUS-1:0] drive_reg;         // Per-bus output enable
	logic [PW-1:0]      man_reg;           // Manual output value
	logic [1:0]         trig_dir_reg;      // Front channel directions
	logic [3:0]         trig_out_reg;      // Trigger output levels
	logic [IRQ_W-1:0]   irq_en_reg;        // Interrupt enables
	logic [IRQ_W-1:0]   irq_st_reg;        // Sticky event bits

	// Data path state
	logic [PW-1:0]      seq_data_reg;      // Last sequencer value
	logic [PW-1:0]      res_data_reg;      // Result waiting to go out
	logic               res_pend_reg;      // A result is waiting
	logic               ovf_live_reg;      // Overflow present
	logic [PW-1:0]      val_reg;           // Unmasked port value
	logic [PW-1:0]      out_reg;           // Value on the pins
	logic [PW-1:0]      oe_n_reg;          // Pin enables, low drives
	logic [PW-1:0]      in_s1_reg;         // Input synchroniser stages
	logic [PW-1:0]      in_s2_reg;
	logic [PW-1:0]      in_s3_reg;
	logic [PW-1:0]      in_filt_reg;       // Accepted input levels
	logic [PW-1:0]      in_val_reg;        // Levels captured at a tick
	logic [ACC_W-1:0]   acc_reg;           // Internal clock accumulator
	logic               irq_reg;
	logic [REG_W-1:0]   rdata_reg;

	// Trigger pin module link
	dtp_trig_if tif ();

	dtp_trig u_trig (
		.clk        (CLK),
		.nrst       (NRST),
		.front_in   (TRIG_FRONT_IN),
		.front_out  (TRIG_FRONT_OUT),
		.front_oe_n (TRIG_FRONT_OE_N),
		.back_in    (TRIG_BACK_IN),
		.back_out   (TRIG_BACK_OUT),
		.ext_clk_in (PORT_EXT_CLK),
		.tif        (tif.trig)
	);

	assign tif.dir     = trig_dir_reg;
	assign tif.out_lvl = trig_out_reg;
	assign TRIG_LEVEL  = tif.in_lvl;

	// Register decode
	wire logic wr_mode  = REG_WR & (REG_ADDR == OFS_MODE);
	wire logic wr_drive = REG_WR & (REG_ADDR == OFS_DRIVE);
	wire logic wr_out   = REG_WR & (REG_ADDR == OFS_OUT_VALUE);
	wire logic wr_clr   = REG_WR & (REG_ADDR == OFS_IRQ_CLR);
	wire logic wr_en    = REG_WR & (REG_ADDR == OFS_IRQ_EN);
	wire logic wr_trig  = REG_WR & (REG_ADDR == OFS_TRIG_CTRL);

	// Port clock: the accumulator carry gives 9 ticks every 16 cycles,
	// which is exactly the internal rate without a second clock domain
	wire logic [ACC_W:0] acc_sum = {1'b0, acc_reg} + {1'b0, PORT_ACC_INC};
	wire logic int_tick = acc_sum[ACC_W];
	// External clock is sampled, so it must stay well below the system
	// clock; the fastest external rates cannot be followed reliably
	wire logic port_tick = clk_ext_reg ? tif.ext_rise : int_tick;

	// Result hand-off between the readout and the port
	wire logic res_mode = mode_reg[1];         // Both result formats
	wire logic res_take = res_mode & RES_VALID;
	wire logic drain    = port_tick & res_pend_reg;
	// A new result while the last one has not gone out yet
	wire logic ovf_ev   = res_take & res_pend_reg & ~drain;
	wire logic res_pend_next = res_mode & (res_take | (res_pend_reg & ~drain));
	wire logic ovf_live_next = res_mode & (ovf_ev | (ovf_live_reg & ~drain));

	// Source selection; system format marks a fresh result in the top bit
	wire logic [PW-1:0] res_sel = res_pend_reg ? res_data_reg : val_reg;
	wire logic [PW-1:0] sys_sel = {res_pend_reg, res_data_reg[PW-2:0]};
	wire logic [PW-1:0] src_val =
		(mode_reg == MODE_MANUAL) ? man_reg :
		(mode_reg == MODE_SEQ)    ? seq_data_reg :
		(mode_reg == MODE_RESULT) ? res_sel : sys_sel;

	// Per-bus drive mask
	logic [PW-1:0] drive_mask;
	genvar b;
	generate
		for (b = 0; b < NUM_BUS; b++)
		begin : g_bus
			// Whole bus switches together
			assign drive_mask[b*BUS_W +: BUS_W] = {BUS_W{drive_reg[b]}};
		end
	endgenerate

	// Input filter: a bit moves once stages two and three agree
	wire logic [PW-1:0] in_filt_next =
		(in_s2_reg & in_s3_reg) | (in_filt_reg & (in_s2_reg ^ in_s3_reg));

	// Events; front triggers count only while used as inputs
	wire logic [3:0] trig_ev = tif.in_rise & {2'b11, ~trig_dir_reg};
	wire logic [IRQ_W-1:0] irq_ev = {trig_ev, ovf_ev};
	// Set wins over a clear in the same cycle
	wire logic [IRQ_W-1:0] irq_clr = wr_clr ? REG_WDATA[IRQ_W-1:0] : '0;
	wire logic [IRQ_W-1:0] irq_st_next = (irq_st_reg & ~irq_clr) | irq_ev;
	wire logic [IRQ_W-1:0] irq_en_next =
		wr_en ? REG_WDATA[IRQ_W-1:0] : irq_en_reg;

	// Read mux; unmapped and write-only offsets read zero
	wire logic [REG_W-1:0] st_word = REG_W'({irq_st_reg[IRQ_OVF_BIT],
		ovf_live_reg}) << OVF_LIVE_BIT;
	wire logic [REG_W-1:0] rd_mux =
		(REG_ADDR == OFS_MODE)      ? (REG_W'(mode_reg) << MODE_SEL_LSB) |
			(REG_W'(clk_ext_reg) << CLK_EXT_BIT) :
		(REG_ADDR == OFS_DRIVE)     ? REG_W'(drive_reg) :
		(REG_ADDR == OFS_OUT_VALUE) ? REG_W'(man_reg) :
		(REG_ADDR == OFS_IN_VALUE)  ? REG_W'(in_val_reg) :
		(REG_ADDR == OFS_STATUS)    ? st_word :
		(REG_ADDR == OFS_IRQ_STAT)  ? REG_W'(irq_st_reg) :
		(REG_ADDR == OFS_IRQ_EN)    ? REG_W'(irq_en_reg) :
		(REG_ADDR == OFS_TRIG_CTRL) ?
			(REG_W'(trig_dir_reg) << TRIG_DIR_LSB) |
			(REG_W'(trig_out_reg) << TRIG_OUT_LSB) :
		(REG_ADDR == OFS_TRIG_STAT) ? REG_W'(tif.in_lvl) : '0;

	// Software-written control
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			mode_reg     <= RST_MODE;
			clk_ext_reg  <= RST_CLK;
			drive_reg    <= RST_DRIVE[NUM_BUS-1:0];
			man_reg      <= RST_VALUE[PW-1:0];
			trig_dir_reg <= RST_DIR;
			trig_out_reg <= RST_TOUT;
		end
		else
		begin
			if (wr_mode)
			begin
				mode_reg    <= REG_WDATA[MODE_SEL_LSB +: 2];
				clk_ext_reg <= REG_WDATA[CLK_EXT_BIT];
			end
			if (wr_drive)
				drive_reg <= REG_WDATA[NUM_BUS-1:0];
			if (wr_out)
				man_reg <= REG_WDATA[PW-1:0];
			if (wr_trig)
			begin
				trig_dir_reg <= REG_WDATA[TRIG_DIR_LSB +: 2];
				trig_out_reg <= REG_WDATA[TRIG_OUT_LSB +: 4];
			end
		end
	end

	// Interrupt status, enables and output level
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			irq_st_reg <= RST_IRQ;
			irq_en_reg <= RST_IRQ;
			irq_reg    <= 1'b0;
		end
		else
		begin
			irq_st_reg <= irq_st_next;
			irq_en_reg <= irq_en_next;
			irq_reg    <= |(irq_st_next & irq_en_next);
		end
	end

	// Source capture and overflow tracking
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			seq_data_reg <= RST_VALUE[PW-1:0];
			res_data_reg <= RST_VALUE[PW-1:0];
			res_pend_reg <= 1'b0;
			ovf_live_reg <= 1'b0;
		end
		else
		begin
			if (SEQ_VALID)
				seq_data_reg <= SEQ_VALUE;
			// Newest result replaces one that was still waiting
			if (res_take)
				res_data_reg <= RES_VALUE;
			res_pend_reg <= res_pend_next;
			ovf_live_reg <= ovf_live_next;
		end
	end

	// Port clock accumulator, stepping every cycle, and pin registers, moving on a tick
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			acc_reg    <= '0;
			val_reg    <= RST_VALUE[PW-1:0];
			out_reg    <= RST_VALUE[PW-1:0];
			oe_n_reg   <= '1;
			in_val_reg <= RST_VALUE[PW-1:0];
		end
		else
		begin
			acc_reg <= acc_sum[ACC_W-1:0];
			if (port_tick)
			begin
				val_reg    <= src_val;
				out_reg    <= src_val & drive_mask;
				oe_n_reg   <= ~drive_mask;
				in_val_reg <= in_filt_next;
			end
		end
	end

	// Input synchroniser; stage one feeds stage two only
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			in_s1_reg   <= '0;
			in_s2_reg   <= '0;
			in_s3_reg   <= '0;
			in_filt_reg <= '0;
		end
		else
		begin
			in_s1_reg   <= PORT_IN;
			in_s2_reg   <= in_s1_reg;
			in_s3_reg   <= in_s2_reg;
			in_filt_reg <= in_filt_next;
		end
	end

	// Read data stands for exactly one cycle after the strobe
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			rdata_reg <= '0;
		else
			rdata_reg <= REG_RD ? rd_mux : '0;
	end

	assign PORT_OUT  = out_reg;
	assign PORT_OE_N = oe_n_reg;
	assign IRQ       = irq_reg;
	assign REG_RDATA = rdata_reg;

endmodule

// ---- dtp_pkg.sv ----
// Shared constants for the digital port and trigger block
package dtp_pkg;

	// Port geometry
	localparam int NUM_BUSES   = 4;     // Independent 8-line buses
	localparam int BUS_WIDTH   = 8;     // Lines per bus
	localparam int NUM_FRONT   = 2;     // Two-way front trigger channels
	localparam int NUM_BACK    = 2;     // Back inputs and back outputs
	localparam int NUM_TRIG    = 4;     // Trigger inputs seen by logic
	localparam int NUM_SYNC    = 5;     // Trigger inputs plus clock pin
	localparam int REG_W       = 32;    // Register data width
	localparam int IRQ_W       = 5;     // Interrupt status width

	// Register byte offsets
	localparam logic [7:0] OFS_MODE      = 8'h00;
	localparam logic [7:0] OFS_DRIVE     = 8'h04;
	localparam logic [7:0] OFS_OUT_VALUE = 8'h08;
	localparam logic [7:0] OFS_IN_VALUE  = 8'h0C;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR   = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h1C;
	localparam logic [7:0] OFS_TRIG_CTRL = 8'h20;
	localparam logic [7:0] OFS_TRIG_STAT = 8'h24;

	// Field positions
	localparam int MODE_SEL_LSB  = 0;   // Output source, two bits
	localparam int CLK_EXT_BIT   = 4;   // 1 selects the external clock
	localparam int OVF_LIVE_BIT  = 0;   // Overflow present now
	localparam int OVF_HIST_BIT  = 1;   // Overflow seen earlier
	localparam int IRQ_OVF_BIT   = 0;   // Overflow event
	localparam int IRQ_TRIG_LSB  = 1;   // Trigger rising edges, four bits
	localparam int TRIG_DIR_LSB  = 0;   // Front channel is output
	localparam int TRIG_OUT_LSB  = 8;   // Trigger output levels, four bits

	// Output source modes
	localparam logic [1:0] MODE_MANUAL = 2'h0;
	localparam logic [1:0] MODE_SEQ    = 2'h1;
	localparam logic [1:0] MODE_RESULT = 2'h2;
	localparam logic [1:0] MODE_SYSFMT = 2'h3;

	// Values after reset
	localparam logic [1:0]  RST_MODE  = 2'h0;
	localparam logic        RST_CLK   = 1'b0;
	localparam logic [3:0]  RST_DRIVE = 4'h0;
	localparam logic [31:0] RST_VALUE = 32'h0000_0000;
	localparam logic [1:0]  RST_DIR   = 2'h0;
	localparam logic [3:0]  RST_TOUT  = 4'h0;
	localparam logic [4:0]  RST_IRQ   = 5'h00;

	// Internal port clock made from the system clock by a phase accumulator
	localparam longint SYS_CLK_KHZ  = 100000;
	localparam longint PORT_CLK_KHZ = 56250;
	localparam int     ACC_W        = 16;
	localparam logic [15:0] PORT_ACC_INC =
		16'(PORT_CLK_KHZ * 65536 / SYS_CLK_KHZ);

endpackage

// ---- dtp_trig_if.sv ----
// Carrier between the port core and the trigger pin module
`timescale 1ns/10ps
interface dtp_trig_if;
	logic [1:0] dir;        // Front channel drives when set
	logic [3:0] out_lvl;    // Levels for the four trigger outputs
	logic [3:0] in_lvl;     // Filtered trigger input levels
	logic [3:0] in_rise;    // One-cycle rising edge pulses
	logic       ext_lvl;    // Filtered external clock level
	logic       ext_rise;   // One-cycle rising edge of the clock pin

	modport ctrl (output dir, output out_lvl,
		input in_lvl, input in_rise, input ext_lvl, input ext_rise);
	modport trig (input dir, input out_lvl,
		output in_lvl, output in_rise, output ext_lvl, output ext_rise);
endinterface

// ---- dtp_trig.sv ----
// Trigger pins and clock pin: synchronisers, edge pulses, output drive
`timescale 1ns/10ps
module dtp_trig
	import dtp_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 nrst,
	// Pins
	input  wire logic [NUM_FRONT-1:0] front_in,
	output logic      [NUM_FRONT-1:0] front_out,
	output logic      [NUM_FRONT-1:0] front_oe_n,
	input  wire logic [NUM_BACK-1:0]  back_in,
	output logic      [NUM_BACK-1:0]  back_out,
	input  wire logic                 ext_clk_in,
	// Core side
	dtp_trig_if.trig                  tif
);

	// Raw pins in channel order: ch1, ch2, in3, in4, clock pin
	wire logic [NUM_SYNC-1:0] raw_in = {ext_clk_in, back_in, front_in};
	logic      [NUM_SYNC-1:0] lvl_vec;    // Filtered levels
	logic      [NUM_SYNC-1:0] rise_vec;   // Edge pulses

	// One synchroniser and filter per input
	genvar g;
	generate
		for (g = 0; g < NUM_SYNC; g++)
		begin : g_sync
			logic s1_reg;     // Metastability stage, read only by s2
			logic s2_reg;
			logic s3_reg;
			logic filt_reg;   // Accepted level
			logic rise_reg;
			// Level only moves when the second and third stage agree
			wire logic agree = (s2_reg == s3_reg);
			wire logic filt_next = agree ? s3_reg : filt_reg;
			always_ff @(posedge clk)
			begin
				if (!nrst)
				begin
					s1_reg   <= 1'b0;
					s2_reg   <= 1'b0;
					s3_reg   <= 1'b0;
					filt_reg <= 1'b0;
					rise_reg <= 1'b0;
				end
				else
				begin
					s1_reg   <= raw_in[g];
					s2_reg   <= s1_reg;
					s3_reg   <= s2_reg;
					filt_reg <= filt_next;
					rise_reg <= filt_next & ~filt_reg;
				end
			end
			assign lvl_vec[g]  = filt_reg;
			assign rise_vec[g] = rise_reg;
		end
	endgenerate

	// Hand the filtered view to the core
	assign tif.in_lvl   = lvl_vec[NUM_TRIG-1:0];
	assign tif.in_rise  = rise_vec[NUM_TRIG-1:0];
	assign tif.ext_lvl  = lvl_vec[NUM_SYNC-1];
	assign tif.ext_rise = rise_vec[NUM_SYNC-1];

	// Registered trigger outputs; front pins float as inputs after reset
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			front_out  <= 2'h0;
			front_oe_n <= 2'h3;
			back_out   <= 2'h0;
		end
		else
		begin
			front_out  <= tif.out_lvl[1:0];
			front_oe_n <= ~tif.dir;
			back_out   <= tif.out_lvl[3:2];
		end
	end

endmodule

// ---- dtp_far.sv ----
// Model of the digital equipment wired to the parallel port
`timescale 1ns/10ps
module dtp_far
	import dtp_pkg::*;
(
	// Bench clock, used only to pace the port clock
	input  wire logic        clk,
	// Device side of the lines
	input  wire logic [31:0] dev_out,
	input  wire logic [31:0] dev_oe_n,
	// Far-side controls
	input  wire logic [31:0] pattern,
	input  wire logic        clk_run,
	// Resolved levels
	output logic      [31:0] line_lvl,
	output logic             ext_clk
);
	logic [3:0] div_reg;	// Counts system cycles of the port clock

	// Equipment drives only lines that the device leaves as inputs
	assign line_lvl = (dev_out & ~dev_oe_n) | (pattern & dev_oe_n);

	// Port clock of 6.25 MHz, inside the allowed span; low when idle
	assign ext_clk = clk_run && div_reg[3];

	// Counter restarts whenever the clock is stopped
	always_ff @(posedge clk)
	begin
		if (!clk_run)
			div_reg <= 4'h0;
		else
			div_reg <= div_reg + 4'h1;
	end
endmodule

// ---- dtp_top_chk.sv ----
// Port-level assertions for the digital port block
`timescale 1ns/10ps
module dtp_top_chk
	import dtp_pkg::*;
#(
	parameter int NUM_BUS = NUM_BUSES,	// Buses in the port
	parameter int BUS_W   = BUS_WIDTH	// Lines per bus
)
(
	// Clock and reset
	input wire logic                     CLK,
	input wire logic                     NRST,
	// Register port
	input wire logic [7:0]               REG_ADDR,
	input wire logic [REG_W-1:0]         REG_WDATA,
	input wire logic                     REG_WR,
	input wire logic                     REG_RD,
	input wire logic [REG_W-1:0]         REG_RDATA,
	input wire logic                     IRQ,
	// Pins
	input wire logic [NUM_BUS*BUS_W-1:0] PORT_OUT,
	input wire logic [NUM_BUS*BUS_W-1:0] PORT_OE_N,
	input wire logic [NUM_FRONT-1:0]     TRIG_FRONT_OUT,
	input wire logic [NUM_FRONT-1:0]     TRIG_FRONT_OE_N,
	input wire logic [NUM_BACK-1:0]      TRIG_BACK_OUT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// Decoded register writes
	wire logic wr_drv  = REG_WR && REG_ADDR == OFS_DRIVE;
	wire logic wr_trig = REG_WR && REG_ADDR == OFS_TRIG_CTRL;
	wire logic wr_mode = REG_WR && REG_ADDR == OFS_MODE;
	wire logic wr_en   = REG_WR && REG_ADDR == OFS_IRQ_EN;

	logic [11:0]              trig_reg;	// Last trigger control write
	logic [3:0]               drv_reg;	// Last drive write
	logic                     ext_reg;	// External clock selected
	logic [NUM_BUS*BUS_W-1:0] oe_exp;	// Enables implied by drive bits
	logic                     oe_even;	// Each bus enabled as a whole

	// Shadow of software writes, to predict the pins
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			trig_reg <= '0;
			drv_reg  <= '0;
			ext_reg  <= 1'b0;
		end
		else
		begin
			if (wr_trig)
				trig_reg <= REG_WDATA[11:0];
			if (wr_drv)
				drv_reg <= REG_WDATA[3:0];
			if (wr_mode)
				ext_reg <= REG_WDATA[CLK_EXT_BIT];
		end
	end

	// Expand drive bits and look for a half-enabled bus
	always_comb
	begin
		oe_even = 1'b1;
		for (int b = 0; b < NUM_BUS; b++)
		begin
			oe_exp[b*BUS_W +: BUS_W] = {BUS_W{drv_reg[b]}};
			if (|PORT_OE_N[b*BUS_W +: BUS_W] &&
				!(&PORT_OE_N[b*BUS_W +: BUS_W]))
				oe_even = 1'b0;
		end
	end

	property p_oe_bus;
		oe_even;
	endproperty
	a_oe_bus: assert property (p_oe_bus)
		else $error("bus enabled only in part");

	property p_out_idle;
		(PORT_OUT & PORT_OE_N) == '0;
	endproperty
	a_out_idle: assert property (p_out_idle)
		else $error("value on an undriven line");

	property p_rst_oe;
		$rose(NRST) |-> &PORT_OE_N && &TRIG_FRONT_OE_N;
	endproperty
	a_rst_oe: assert property (p_rst_oe)
		else $error("pins driven after reset");

	property p_drv;
		wr_drv && !ext_reg |-> ##[1:4] PORT_OE_N == ~oe_exp;
	endproperty
	a_drv: assert property (p_drv)
		else $error("drive write not applied");

	property p_rd_idle;
		!REG_RD |=> REG_RDATA == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");

	property p_stat_rd;
		REG_RD && REG_ADDR == OFS_STATUS |=> REG_RDATA[REG_W-1:2] == '0;
	endproperty
	a_stat_rd: assert property (p_stat_rd)
		else $error("status high bits set");

	property p_irq_off;
		wr_en && REG_WDATA[IRQ_W-1:0] == '0 |-> ##[1:2] !IRQ;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt stays with all masked");

	property p_trig;
		wr_trig |-> ##2 TRIG_FRONT_OE_N == ~trig_reg[1:0]
			&& {TRIG_BACK_OUT, TRIG_FRONT_OUT} == trig_reg[11:8];
	endproperty
	a_trig: assert property (p_trig)
		else $error("trigger outputs differ from control");

	// Main scenarios reached
	c_irq: cover property ($rose(IRQ));
	c_front: cover property (TRIG_FRONT_OE_N != 2'b11);
	c_ext: cover property (ext_reg && $changed(PORT_OUT));
endmodule

bind dtp_top dtp_top_chk #(.NUM_BUS(NUM_BUS), .BUS_W(BUS_W)) dtp_top_chk_inst (
	.CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
	.PORT_OUT(PORT_OUT), .PORT_OE_N(PORT_OE_N),
	.TRIG_FRONT_OUT(TRIG_FRONT_OUT), .TRIG_FRONT_OE_N(TRIG_FRONT_OE_N),
	.TRIG_BACK_OUT(TRIG_BACK_OUT));

// ---- tb_dtp_top.sv ----
// Self-checking bench for the digital port block
`timescale 1ns/10ps
module tb_dtp_top
	import dtp_pkg::*;
;
	logic        clk, nrst, wr, rd, seq_vld, res_vld, clk_run, ext_clk;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, seq_val, res_val, port_in, port_out;
	logic [31:0] port_oe_n, prev;
	logic [1:0]  front_drv, front_out, front_oe_n, back_in, back_out;
	logic [3:0]  trig_lvl;
	logic        irq, seen;
	int          n_fail, checks;
	// Offsets that read zero after reset, the last one unmapped
	logic [7:0]  zofs [10] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
		8'h1C, 8'h20, 8'h24, 8'h28};
	// Pattern the equipment shows on lines it drives
	wire  [31:0] pattern = 32'h3C96_5A0F;
	wire  [31:0] v = 32'hA5C3_1E7F;	// Manual value
	wire  [31:0] m = 32'h00FF_00FF;	// Buses 0 and 2 driven
	wire  [31:0] r = 32'h8765_4321;	// Readout result
	// Front pin level: device wins while it drives the channel
	wire  [1:0]  front_in = (front_out & ~front_oe_n) | (front_drv & front_oe_n);

	dtp_top dtp_top_inst (.CLK(clk), .NRST(nrst), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.IRQ(irq), .SEQ_VALUE(seq_val), .SEQ_VALID(seq_vld),
		.RES_VALUE(res_val), .RES_VALID(res_vld), .PORT_IN(port_in),
		.PORT_OUT(port_out), .PORT_OE_N(port_oe_n), .PORT_EXT_CLK(ext_clk),
		.TRIG_FRONT_IN(front_in), .TRIG_FRONT_OUT(front_out),
		.TRIG_FRONT_OE_N(front_oe_n), .TRIG_BACK_IN(back_in),
		.TRIG_BACK_OUT(back_out), .TRIG_LEVEL(trig_lvl));

	dtp_far dtp_far_inst (.clk(clk), .dev_out(port_out),
		.dev_oe_n(port_oe_n), .pattern(pattern), .clk_run(clk_run),
		.line_lvl(port_in), .ext_clk(ext_clk));

	// System clock, 10 ns period
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compare and count; report at once on a difference
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One-cycle register write
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read; data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	// Let a number of cycles pass
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Single place where the run ends
	task automatic test_done;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Cuts a hang short, well past the expected run length
	initial
	begin
		idle(4000);
		n_fail++;
		test_done;
	end

	// Main sequence
	initial
	begin
		{nrst, wr, rd, seq_vld, res_vld, clk_run} = '0;
		{addr, wdata, seq_val, res_val, front_drv, back_in} = '0;
		n_fail = 0;
		checks = 0;
		idle(4);
		nrst <= 1'b1;
		// Reset values, write-only and unmapped places read as zero
		foreach (zofs[i])
			rchk(zofs[i], 32'h0000_0000);
		chk(port_oe_n, 32'hFFFF_FFFF);
		// Manual value on two buses, the others read back the far side
		wreg(OFS_OUT_VALUE, v);
		wreg(OFS_DRIVE, 32'h0000_0005);
		idle(12);
		chk(port_out, v & m);
		chk(port_oe_n, ~m);
		rchk(OFS_IN_VALUE, (v & m) | (pattern & ~m));
		wreg(OFS_DRIVE, 32'h0000_000F);
		// Sequencer source
		wreg(OFS_MODE, {30'h0, MODE_SEQ});
		@(posedge clk);
		seq_val <= 32'h1234_5678;
		seq_vld <= 1'b1;
		@(posedge clk);
		seq_vld <= 1'b0;
		idle(6);
		chk(port_out, 32'h1234_5678);
		// Result source, plain and with fresh-data top bit
		wreg(OFS_MODE, {30'h0, MODE_RESULT});
		@(posedge clk);
		res_val <= r;
		res_vld <= 1'b1;
		@(posedge clk);
		res_vld <= 1'b0;
		idle(6);
		chk(port_out, r);
		wreg(OFS_MODE, {30'h0, MODE_SYSFMT});
		res_vld <= 1'b1;
		@(posedge clk);
		res_vld <= 1'b0;
		seen = 1'b0;
		repeat (8)
		begin
			@(posedge clk);
			#1 seen = seen | port_out[31];
		end
		chk({31'h0, seen}, 32'h1);
		idle(8);
		chk(port_out, {1'b0, r[30:0]});
		// Results faster than the port: overflow and interrupt
		wreg(OFS_IRQ_EN, 32'h0000_0001);
		wreg(OFS_MODE, {30'h0, MODE_RESULT});
		res_vld <= 1'b1;
		idle(6);
		res_vld <= 1'b0;
		idle(10);
		rchk(OFS_STATUS, 32'h0000_0002);
		rchk(OFS_IRQ_STAT, 32'h0000_0001);
		chk({31'h0, irq}, 32'h1);
		wreg(OFS_IRQ_EN, 32'h0000_0000);
		idle(2);
		chk({31'h0, irq}, 32'h0);
		wreg(OFS_IRQ_EN, 32'h0000_001F);
		wreg(OFS_IRQ_CLR, 32'h0000_0001);
		rchk(OFS_STATUS, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0);
		// Trigger channels: front 1 drives, the rest are inputs
		wreg(OFS_TRIG_CTRL, 32'h0000_0A01);
		idle(3);
		chk({26'h0, front_oe_n, front_out, back_out}, 32'h2A);
		front_drv <= 2'b11;
		back_in <= 2'b11;
		idle(10);
		rchk(OFS_IRQ_STAT, 32'h0000_001C);
		chk({28'h0, trig_lvl}, 32'hE);
		rchk(OFS_TRIG_STAT, 32'h0000_000E);
		chk({31'h0, irq}, 32'h1);
		wreg(OFS_IRQ_CLR, 32'h0000_001F);
		rchk(OFS_IRQ_STAT, 32'h0000_0000);
		// External clock stopped: nothing drains, so overflow stays live
		wreg(OFS_MODE, 32'h0000_0012);
		res_vld <= 1'b1;
		idle(2);
		res_vld <= 1'b0;
		idle(2);
		rchk(OFS_STATUS, 32'h0000_0003);
		// Leaving result mode drops the live flag, the sticky one stays
		wreg(OFS_MODE, 32'h0000_0010);
		rchk(OFS_STATUS, 32'h0000_0002);
		// External clock: nothing moves until the far side clocks
		idle(5);
		prev = port_out;
		wreg(OFS_OUT_VALUE, 32'h5555_AAAA);
		idle(30);
		chk(port_out, prev);
		clk_run <= 1'b1;
		idle(40);
		chk(port_out, 32'h5555_AAAA);
		clk_run <= 1'b0;
		idle(2);
		test_done;
	end
endmodule
